// ==== rpcg_params.svh ====
// Constants for the run-mode port clock gating block.
// Assumes one 100 MHz clock and a plain register port.
`ifndef RPCG_PARAMS_SVH
`define RPCG_PARAMS_SVH

`define RPCG_ADDR_W         12
`define RPCG_DATA_W         32
`define RPCG_NPORTS         5
`define RPCG_PORT_MSB       4
`define RPCG_SEL_W          3
`define RPCG_CNT_W          16

`define RPCG_RUN_GATE_OFS   12'h108
`define RPCG_FAULT_STAT_OFS 12'h200
`define RPCG_FAULT_MASK_OFS 12'h204
`define RPCG_FAULT_INFO_OFS 12'h208
`define RPCG_FAULT_CNT_OFS  12'h20C

`define RPCG_RUN_GATE_RST   5'h00
`define RPCG_STAT_RST       5'h00
`define RPCG_MASK_RST       5'h00
`define RPCG_CNT_RST        16'h0000
`define RPCG_CNT_MAX        16'hFFFF
`define RPCG_CNT_ONE        16'h0001
`define RPCG_WORD_ZERO      32'h0000_0000
`define RPCG_INFO_WR_BIT    8
`define RPCG_INFO_VLD_BIT   15

`endif

// ==== rpcg_pkg.sv ====
// Types shared by the port clock gating block.
// Assumes rpcg_params.svh supplies widths.
`include "rpcg_params.svh"
package rpcg_pkg;
  typedef logic [`RPCG_PORT_MSB:0]     rpcg_port_mask_t;
  typedef logic [`RPCG_SEL_W-1:0]      rpcg_port_sel_t;
  typedef logic [`RPCG_ADDR_W-1:0]     rpcg_addr_t;
  typedef logic [`RPCG_DATA_W-1:0]     rpcg_word_t;
  typedef logic [`RPCG_CNT_W-1:0]      rpcg_count_t;
  typedef enum logic [2:0] {
    RPCG_ACC_IDLE  = 3'h1,
    RPCG_ACC_GRANT = 3'h2,
    RPCG_ACC_FAULT = 3'h4
  } rpcg_acc_t;
endpackage

// ==== rpcg_clk_gate.sv ====
// Glitch-free clock gating cell for one port clock.
// Assumes en is a flop output timed to the rising edge of clk.
`timescale 1ns/1ns
module rpcg_clk_gate (
  input  wire logic clk,
  input  wire logic en,
  output logic      gclk
);
  logic en_lat;

  // Enable only changes while clk is low
  always_latch begin
    if (!clk) begin
      en_lat = en;
    end
  end

  assign gclk = clk & en_lat;
endmodule

// ==== rpcg_top.sv ====
// Run-mode clock gating for five port blocks, with bus fault
// detection for accesses to unclocked ports and a fault interrupt.
// Assumes the fabric access inputs come from logic on mclk.
`timescale 1ns/1ns
`include "rpcg_params.svh"
module rpcg_top (
  input  wire logic                       mclk,
  input  wire logic                       rst,
  input  wire logic                       clk_en,
  input  wire logic [`RPCG_ADDR_W-1:0]    reg_addr,
  input  wire logic [`RPCG_DATA_W-1:0]    reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output logic      [`RPCG_DATA_W-1:0]    reg_rdata,
  input  wire logic                       port_acc_valid,
  input  wire logic [`RPCG_SEL_W-1:0]     port_acc_sel,
  input  wire logic                       port_acc_write,
  output logic                            port_acc_grant,
  output logic                            port_acc_fault,
  output logic      [`RPCG_PORT_MSB:0]    port_clk_en,
  output logic      [`RPCG_PORT_MSB:0]    port_clk,
  output logic                            irq
);

  rpcg_pkg::rpcg_port_mask_t run_gate;
  rpcg_pkg::rpcg_port_mask_t fault_stat;
  rpcg_pkg::rpcg_port_mask_t fault_mask;
  rpcg_pkg::rpcg_port_mask_t fault_set;
  rpcg_pkg::rpcg_port_mask_t next_fault_stat;
  rpcg_pkg::rpcg_port_mask_t stat_clr;
  rpcg_pkg::rpcg_port_sel_t  fault_port;
  rpcg_pkg::rpcg_count_t     fault_cnt;
  rpcg_pkg::rpcg_count_t     next_fault_cnt;
  rpcg_pkg::rpcg_word_t      next_rdata;
  rpcg_pkg::rpcg_acc_t       acc_state;
  rpcg_pkg::rpcg_acc_t       next_acc_state;
  logic                      fault_wr;
  logic                      fault_vld;
  logic                      sel_legal;
  logic                      sel_clocked;
  logic                      acc_bad;
  logic                      wr_gate;
  logic                      wr_stat;
  logic                      wr_mask;
  logic                      wr_cnt;

  // Register write decode
  assign wr_gate = reg_wr && (reg_addr == `RPCG_RUN_GATE_OFS);
  assign wr_stat = reg_wr && (reg_addr == `RPCG_FAULT_STAT_OFS);
  assign wr_mask = reg_wr && (reg_addr == `RPCG_FAULT_MASK_OFS);
  assign wr_cnt  = reg_wr && (reg_addr == `RPCG_FAULT_CNT_OFS);

  // Run-mode enables, only the low five bits are stored
  always_ff @(posedge mclk) begin
    if (rst) begin
      run_gate <= `RPCG_RUN_GATE_RST;
    end else if (clk_en && wr_gate) begin
      run_gate <= reg_wdata[`RPCG_PORT_MSB:0];
    end
  end

  // Registered copy of the enables for the port blocks
  always_ff @(posedge mclk) begin
    if (rst) begin
      port_clk_en <= `RPCG_RUN_GATE_RST;
    end else if (clk_en) begin
      port_clk_en <= run_gate;
    end
  end

  // One gating cell per port
  genvar gi;
  generate
    for (gi = 0; gi < `RPCG_NPORTS; gi = gi + 1) begin : g_gate
      rpcg_clk_gate u_gate (
        .clk  (mclk),
        .en   (port_clk_en[gi]),
        .gclk (port_clk[gi])
      );
    end
  endgenerate

  // Access checking against the enables the port actually sees
  assign sel_legal   = (port_acc_sel <= rpcg_pkg::rpcg_port_sel_t'(`RPCG_PORT_MSB));
  assign sel_clocked = sel_legal && port_clk_en[port_acc_sel];
  assign acc_bad     = port_acc_valid && !sel_clocked;

  always_comb begin
    next_acc_state = rpcg_pkg::RPCG_ACC_IDLE;
    if (port_acc_valid) begin
      if (acc_bad) begin
        next_acc_state = rpcg_pkg::RPCG_ACC_FAULT;
      end else begin
        next_acc_state = rpcg_pkg::RPCG_ACC_GRANT;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      acc_state <= rpcg_pkg::RPCG_ACC_IDLE;
    end else if (clk_en) begin
      acc_state <= next_acc_state;
    end
  end

  // Answer pulses, one cycle after the access
  always_ff @(posedge mclk) begin
    if (rst) begin
      port_acc_grant <= 1'b0;
      port_acc_fault <= 1'b0;
    end else if (clk_en) begin
      port_acc_grant <= (next_acc_state == rpcg_pkg::RPCG_ACC_GRANT);
      port_acc_fault <= (next_acc_state == rpcg_pkg::RPCG_ACC_FAULT);
    end
  end

  // Fault events per port; out-of-range selects land on no bit
  always_comb begin
    fault_set = `RPCG_STAT_RST;
    if (acc_bad && sel_legal) begin
      fault_set[port_acc_sel] = 1'b1;
    end
  end

  // Sticky status, write one to clear, a new event wins
  always_comb begin
    stat_clr = `RPCG_STAT_RST;
    if (wr_stat) begin
      stat_clr = reg_wdata[`RPCG_PORT_MSB:0];
    end
    next_fault_stat = (fault_stat & ~stat_clr) | fault_set;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      fault_stat <= `RPCG_STAT_RST;
    end else if (clk_en) begin
      fault_stat <= next_fault_stat;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      fault_mask <= `RPCG_MASK_RST;
    end else if (clk_en && wr_mask) begin
      fault_mask <= reg_wdata[`RPCG_PORT_MSB:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      irq <= 1'b0;
    end else if (clk_en) begin
      irq <= |(next_fault_stat & fault_mask);
    end
  end

  // Details of the most recent fault
  always_ff @(posedge mclk) begin
    if (rst) begin
      fault_port <= '0;
      fault_wr   <= 1'b0;
      fault_vld  <= 1'b0;
    end else if (clk_en) begin
      if (acc_bad) begin
        fault_port <= port_acc_sel;
        fault_wr   <= port_acc_write;
        fault_vld  <= 1'b1;
      end else if (wr_stat && (next_fault_stat == `RPCG_STAT_RST)) begin
        fault_vld  <= 1'b0;
      end
    end
  end

  // Saturating fault counter, any write clears, a new fault wins unless the count is saturated
  always_comb begin
    next_fault_cnt = fault_cnt;
    if (wr_cnt) begin
      next_fault_cnt = `RPCG_CNT_RST;
    end
    if (acc_bad && (fault_cnt != `RPCG_CNT_MAX)) begin
      next_fault_cnt = wr_cnt ? `RPCG_CNT_ONE
                              : rpcg_pkg::rpcg_count_t'(fault_cnt + `RPCG_CNT_ONE);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      fault_cnt <= `RPCG_CNT_RST;
    end else if (clk_en) begin
      fault_cnt <= next_fault_cnt;
    end
  end

  // Read mux; reserved bits and unmapped addresses read zero
  always_comb begin
    next_rdata = `RPCG_WORD_ZERO;
    if (reg_rd) begin
      unique case (reg_addr)
        `RPCG_RUN_GATE_OFS: begin
          next_rdata[`RPCG_PORT_MSB:0] = run_gate;
        end
        `RPCG_FAULT_STAT_OFS: begin
          next_rdata[`RPCG_PORT_MSB:0] = fault_stat;
        end
        `RPCG_FAULT_MASK_OFS: begin
          next_rdata[`RPCG_PORT_MSB:0] = fault_mask;
        end
        `RPCG_FAULT_INFO_OFS: begin
          next_rdata[`RPCG_SEL_W-1:0]      = fault_port;
          next_rdata[`RPCG_INFO_WR_BIT]    = fault_wr;
          next_rdata[`RPCG_INFO_VLD_BIT]   = fault_vld;
        end
        `RPCG_FAULT_CNT_OFS: begin
          next_rdata[`RPCG_CNT_W-1:0] = fault_cnt;
        end
        default: begin
          next_rdata = `RPCG_WORD_ZERO;
        end
      endcase
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge mclk) begin
    if (rst) begin
      reg_rdata <= `RPCG_WORD_ZERO;
    end else if (clk_en) begin
      reg_rdata <= next_rdata;
    end
  end

endmodule

// ==== rpcg_props.sv ====
// Checker for the port clock gating block.
// Assumes a bind onto rpcg_top with clk_en held high.
`timescale 1ns/1ns
module rpcg_props (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        port_acc_valid,
  input wire logic [2:0]  port_acc_sel,
  input wire logic        port_acc_grant,
  input wire logic        port_acc_fault,
  input wire logic [4:0]  port_clk_en,
  input wire logic [4:0]  port_clk
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_reset_clear: assert property (
    $fell(rst) |-> port_clk_en == 5'h00 && reg_rdata == 32'h0) else $error("reset state");
  a_gate_write: assert property (
    reg_wr && reg_addr == 12'h108 |=> ##1 {27'h0, port_clk_en} == ($past(reg_wdata, 2) & 32'h1F))
    else $error("enable write");
  a_gate_read: assert property (
    reg_rd && reg_addr == 12'h108 |=> reg_rdata == {27'h0, port_clk_en}) else $error("gate read");
  a_fault_gated: assert property (
    port_acc_valid && (port_acc_sel > 3'h4 || !port_clk_en[port_acc_sel])
    |=> port_acc_fault && !port_acc_grant) else $error("no fault");
  a_grant_clocked: assert property (
    port_acc_valid && port_acc_sel < 3'h5 && port_clk_en[port_acc_sel]
    |=> port_acc_grant && !port_acc_fault) else $error("no grant");
  a_clk_follows_en: assert property (@(negedge mclk)
    port_clk == $past(port_clk_en)) else $error("gated clock");
  a_no_low_glitch: assert property (
    port_clk == 5'h00) else $error("clock glitch");
  a_run_only: assert property (
    !(reg_wr && reg_addr == 12'h108) |=> ##1 $stable(port_clk_en)) else $error("gate moved");
endmodule

bind rpcg_top rpcg_props u_props (
  .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .port_acc_valid(port_acc_valid),
  .port_acc_sel(port_acc_sel), .port_acc_grant(port_acc_grant),
  .port_acc_fault(port_acc_fault), .port_clk_en(port_clk_en), .port_clk(port_clk));

// ==== rpcg_port_model.sv ====
// Five port blocks, each counting edges of its gated clock.
// Assumes port_clk comes straight from the gating block.
`timescale 1ns/1ns
module rpcg_port_model (
  input wire logic [4:0] port_clk
);
  int edges [5] = '{default: 0};
  for (genvar i = 0; i < 5; i++) begin : g_port
    always @(posedge port_clk[i]) begin
      edges[i] <= edges[i] + 1;
    end
  end
endmodule

// ==== testbench.sv ====
// Bench for the port clock gating block: table of bus cycles, then clock, fault record and reset tests.
// Assumes rpcg_top, rpcg_props and rpcg_port_model are compiled first.
`timescale 1ns/1ns
module testbench;
  typedef struct packed {
    logic [1:0]  op;
    logic [11:0] a;
    logic [31:0] d;
    logic [31:0] e;
  } rpcg_row_t;
  // Ops: 0 write, 1 read, 2 port access (select in d), 3 idle
  rpcg_row_t   rows [16] = '{
    '{2'h1, 12'h108, 32'h0, 32'h0}, '{2'h0, 12'h204, 32'h1F, 32'h0},
    '{2'h2, 12'h000, 32'h0, 32'h6}, '{2'h0, 12'h108, 32'hFFFFFFFF, 32'h4},
    '{2'h1, 12'h108, 32'h0, 32'h1F}, '{2'h2, 12'h000, 32'h4, 32'h5},
    '{2'h2, 12'h000, 32'h5, 32'h6}, '{2'h0, 12'h108, 32'h0A, 32'h4},
    '{2'h1, 12'h300, 32'h0, 32'h0}, '{2'h2, 12'h000, 32'h2, 32'h6},
    '{2'h2, 12'h000, 32'h1, 32'h5}, '{2'h1, 12'h200, 32'h0, 32'h5},
    '{2'h0, 12'h200, 32'h5, 32'h0}, '{2'h0, 12'h118, 32'h1F, 32'h0},
    '{2'h1, 12'h108, 32'h0, 32'h0A}, '{2'h3, 12'h000, 32'h0, 32'h0}};
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic [11:0] reg_addr = 12'h000;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        port_acc_valid = 1'b0;
  logic [2:0]  port_acc_sel = 3'h0;
  logic [31:0] reg_rdata;
  logic        port_acc_grant;
  logic        port_acc_fault;
  logic        irq;
  logic [4:0]  port_clk_en;
  logic [4:0]  port_clk;
  int          err_count = 0;
  int          checks = 0;
  int          cycles = 0;
  int          snap [5];

  rpcg_top u_rpcg_top (.mclk(mclk), .rst(rst), .clk_en(1'b1), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .port_acc_valid(port_acc_valid), .port_acc_sel(port_acc_sel), .port_acc_write(1'b0),
    .port_acc_grant(port_acc_grant), .port_acc_fault(port_acc_fault),
    .port_clk_en(port_clk_en), .port_clk(port_clk), .irq(irq));
  rpcg_port_model u_rpcg_port_model (.port_clk(port_clk));

  initial forever #5 mclk = ~mclk;

  // Drive one cycle at the edge; outputs read at the next edge before it updates them
  task automatic cyc(input logic [1:0] op, input logic [11:0] a, input logic [31:0] d);
    reg_wr <= op == 2'h0;
    reg_rd <= op == 2'h1;
    port_acc_valid <= op == 2'h2;
    reg_addr <= a;
    reg_wdata <= d;
    port_acc_sel <= d[2:0];
    @(posedge mclk);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 1000) begin
      err_count++;
      end_of_test();
    end
  end

  initial begin
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    // Ports are enabled only after the first access, so that early access must fault
    for (int i = 0; i < 16; i++) begin
      cyc(rows[i].op, rows[i].a, rows[i].d);
      if (i > 0) chk(rows[i-1].op == 2'h1 ? reg_rdata : {29'h0, irq, port_acc_fault, port_acc_grant}, rows[i-1].e);
    end
    $display("table test done");
    foreach (snap[i]) snap[i] = u_rpcg_port_model.edges[i];
    repeat (10) @(posedge mclk);
    foreach (snap[i]) chk(u_rpcg_port_model.edges[i] - snap[i], (i == 1 || i == 3) ? 10 : 0);
    $display("clock test done");
    // Three faults so far; last one on port 2, its status since cleared
    cyc(2'h1, 12'h20C, 32'h0);
    cyc(2'h1, 12'h208, 32'h0);
    chk(reg_rdata, 32'h3);
    cyc(2'h3, 12'h000, 32'h0);
    chk(reg_rdata, 32'h2);
    $display("fault record test done");
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    cyc(2'h1, 12'h108, 32'h0);
    chk({27'h0, port_clk_en}, 32'h0);
    cyc(2'h2, 12'h000, 32'h3);
    chk(reg_rdata, 32'h0);
    cyc(2'h3, 12'h000, 32'h0);
    chk({29'h0, irq, port_acc_fault, port_acc_grant}, 32'h2);
    $display("reset test done");
    end_of_test();
  end
endmodule
